// File: core/bcr_backplane_conn_mem.sv
// Purpose: Backplane connection memory, timeslot fetch and register map
// Assumes: Host holds address and data stable while chip select is low
// Notes:   Data memories are outside; read latency one clock
`include "bcr_defs.svh"
module bcr_backplane_conn_mem #(
  parameter int          BIT_DIV   = `BCR_BIT_DIV,
  parameter logic [15:0] DEVICE_ID = 16'h5a5a  // Arbitrary value
) (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                host_cs_n,
  input  wire logic                host_rw,
  input  wire logic [14:0]         host_addr,
  input  wire logic [15:0]         host_data_in,
  output logic      [15:0]         host_data_out,
  output logic                     host_data_oe,
  output logic                     host_ack,
  input  wire logic                backplane_output_drive_select,
  output logic                     dm_rd_en,
  output bcr_pkg::bcr_dm_req_t     dm_req,
  input  wire logic [7:0]          dm_rdata,
  output logic      [15:0]         backplane_serial_outputs,
  output logic      [15:0]         backplane_serial_oe,
  output logic      [15:0]         backplane_channel_active,
  output logic                     frame_start,
  output logic                     discriminator_enable,
  output logic      [2:0]          discriminator_mode,
  output logic                     sample_point_mode,
  output logic                     block_program_arm,
  output logic      [15:0]         block_programming,
  output bcr_pkg::bcr_sample_t     local_sample_cfg     [16],
  output bcr_pkg::bcr_sample_t     backplane_sample_cfg [16]
);

  // Pin synchronisers; first stage feeds only the second
  logic [32:0] pin_s1_r;
  logic [32:0] pin_s2_r;
  logic        cs_n_s3_r;
  logic        drive_sel_s1_r;
  logic        drive_sel_s2_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s1_r       <= {1'b1, 32'h0};
      pin_s2_r       <= {1'b1, 32'h0};
      cs_n_s3_r      <= 1'b1;
      drive_sel_s1_r <= 1'b0;
      drive_sel_s2_r <= 1'b0;
    end else begin
      pin_s1_r       <= {host_cs_n, host_rw, host_addr, host_data_in};
      pin_s2_r       <= pin_s1_r;
      cs_n_s3_r      <= pin_s2_r[32];
      drive_sel_s1_r <= backplane_output_drive_select;
      drive_sel_s2_r <= drive_sel_s1_r;
    end
  end

  wire        cs_n_s  = pin_s2_r[32];
  wire        rw_s    = pin_s2_r[31];
  wire [14:0] addr_s  = pin_s2_r[30:16];
  wire [15:0] wdata_s = pin_s2_r[15:0];

  // Access starts on the falling edge of chip select
  wire acc_go   = ~cs_n_s & cs_n_s3_r;
  wire mem_sel  = addr_s[14];
  wire reg_sel  = ~addr_s[14];
  wire [13:0] reg_ofs = addr_s[13:0];
  wire mem_hit  = mem_sel & ~addr_s[13];
  wire [12:0] mem_idx = addr_s[12:0];

  // Register decode
  wire hit_ctrl = reg_sel & (reg_ofs == `BCR_OFS_MAIN_CONTROL);
  wire hit_bpr  = reg_sel & (reg_ofs == `BCR_OFS_BLOCK_PROG);
  wire hit_bist = reg_sel & (reg_ofs == `BCR_OFS_SELF_TEST);
  wire hit_id   = reg_sel & (reg_ofs == `BCR_OFS_DEVICE_ID);

  localparam logic [13:0] GRP_BASE [4] = '{`BCR_OFS_LOCAL_IN_DLY, `BCR_OFS_BP_IN_DLY,
                                           `BCR_OFS_LOCAL_OUT_ADV, `BCR_OFS_BP_OUT_ADV};

  logic [15:0] ctrl_r;
  logic [15:0] bpr_r;
  logic [15:0] bist_r;
  logic [15:0] grp_r   [4][16];
  logic [13:0] grp_ofs [4];
  logic        grp_hit [4];
  logic [15:0] grp_rd  [4];

  // Groups of sixteen: offset subtraction wraps, so one compare covers both ends
  for (genvar g = 0; g < 4; g++) begin : g_grp
    assign grp_ofs[g] = reg_ofs - GRP_BASE[g];
    assign grp_hit[g] = reg_sel & (grp_ofs[g] < `BCR_GRP_SPAN);
    assign grp_rd[g]  = grp_r[g][grp_ofs[g][3:0]];
    for (genvar i = 0; i < 16; i++) begin : g_ent
      wire wr = acc_go & ~rw_s & grp_hit[g] & (grp_ofs[g][3:0] == 4'(i));
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          grp_r[g][i] <= `BCR_REG_RESET;
        end else if (wr) begin
          grp_r[g][i] <= wdata_s;
        end
      end
    end
  end

  // Control state; reserved mode values are stored as written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= `BCR_CTRL_RESET;
      bpr_r  <= `BCR_REG_RESET;
      bist_r <= `BCR_REG_RESET;
    end else if (acc_go & ~rw_s) begin
      if (hit_ctrl) begin
        ctrl_r <= wdata_s;
      end
      if (hit_bpr) begin
        bpr_r <= wdata_s;
      end
      if (hit_bist) begin
        bist_r <= wdata_s;
      end
    end
  end

  wire [15:0] reg_rd = hit_ctrl   ? ctrl_r    :
                       hit_bpr    ? bpr_r     :
                       grp_hit[0] ? grp_rd[0] :
                       grp_hit[1] ? grp_rd[1] :
                       grp_hit[2] ? grp_rd[2] :
                       grp_hit[3] ? grp_rd[3] :
                       hit_bist   ? bist_r    :
                       hit_id     ? DEVICE_ID : 16'h0000;

  wire disc_en  = ctrl_r[`BCR_CTRL_DISC_EN];
  wire smpl_hi  = ctrl_r[`BCR_CTRL_SAMPLE_MODE];
  wire [2:0] disc_mode_eff = disc_en ?
                    ctrl_r[`BCR_CTRL_DISC_MODE_HI:`BCR_CTRL_DISC_MODE_LO] : 3'h0;

  // Per-stream sample configuration, in quarter-bit units
  bcr_pkg::bcr_sample_t lcfg_nxt [16];
  bcr_pkg::bcr_sample_t bcfg_nxt [16];
  for (genvar i = 0; i < 16; i++) begin : g_cfg
    assign lcfg_nxt[i] = smpl_hi ?
                         '{point: grp_r[0][i][1:0], quarter_delay: {grp_r[0][i][4:2], 2'b00}} :
                         '{point: `BCR_PT_3Q, quarter_delay: grp_r[0][i][4:0]};
    assign bcfg_nxt[i] = smpl_hi ?
                         '{point: grp_r[1][i][1:0], quarter_delay: {grp_r[1][i][4:2], 2'b00}} :
                         '{point: `BCR_PT_3Q, quarter_delay: grp_r[1][i][4:0]};
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        local_sample_cfg[i]     <= '{point: `BCR_PT_3Q, quarter_delay: 5'h00};
        backplane_sample_cfg[i] <= '{point: `BCR_PT_3Q, quarter_delay: 5'h00};
      end else begin
        local_sample_cfg[i]     <= lcfg_nxt[i];
        backplane_sample_cfg[i] <= bcfg_nxt[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      discriminator_enable <= 1'b0;
      discriminator_mode   <= 3'h0;
      sample_point_mode    <= 1'b0;
      block_program_arm    <= 1'b0;
      block_programming    <= `BCR_REG_RESET;
    end else begin
      discriminator_enable <= disc_en;
      discriminator_mode   <= disc_mode_eff;
      sample_point_mode    <= smpl_hi;
      block_program_arm    <= ctrl_r[`BCR_CTRL_BLOCK_ARM];
      block_programming    <= bpr_r;
    end
  end

  // Connection memory; a sweep after reset clears it so outputs start inactive
  bcr_pkg::bcr_entry_t bcm_mem [`BCR_MEM_DEPTH];
  logic        init_busy_r;
  logic [12:0] init_idx_r;
  wire         host_mem_wr = acc_go & ~rw_s & mem_hit & ~init_busy_r;
  wire         mem_we      = init_busy_r | host_mem_wr;
  wire  [12:0] mem_waddr   = init_busy_r ? init_idx_r : mem_idx;
  wire  [15:0] mem_wdata   = init_busy_r ? 16'h0000 : wdata_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_busy_r <= 1'b1;
      init_idx_r  <= 13'h0000;
    end else if (init_busy_r) begin
      init_idx_r  <= init_idx_r + 13'h0001;
      init_busy_r <= (init_idx_r != `BCR_LAST_ENTRY);
    end
  end

  always_ff @(posedge clk) begin
    if (mem_we) begin
      bcm_mem[mem_waddr] <= mem_wdata;
    end
  end

  // Host answer, one clock after the access is taken
  logic [15:0] host_mem_q_r;
  logic        resp_r;
  logic        resp_rd_r;
  logic        resp_mem_r;
  logic [15:0] resp_reg_r;

  always_ff @(posedge clk) begin
    host_mem_q_r <= mem_hit ? bcm_mem[mem_idx] : 16'h0000;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resp_r        <= 1'b0;
      resp_rd_r     <= 1'b0;
      resp_mem_r    <= 1'b0;
      resp_reg_r    <= 16'h0000;
      host_data_out <= 16'h0000;
      host_data_oe  <= 1'b0;
      host_ack      <= 1'b0;
    end else begin
      resp_r     <= acc_go;
      resp_rd_r  <= rw_s;
      resp_mem_r <= mem_sel;
      resp_reg_r <= reg_rd;
      if (cs_n_s) begin
        host_data_oe <= 1'b0;
        host_ack     <= 1'b0;
      end else if (resp_r) begin
        host_data_out <= resp_rd_r ? (resp_mem_r ? host_mem_q_r : resp_reg_r) : host_data_out;
        host_data_oe  <= resp_rd_r;
        host_ack      <= 1'b1;
      end
    end
  end

  // Timeslot timing
  logic       bit_en;
  logic [2:0] bit_cnt_r;
  logic [8:0] chan_r;
  wire        chan_edge = bit_en & (bit_cnt_r == `BCR_LAST_BIT);

  bcr_bit_div #(.DIV(BIT_DIV)) u_div (
    .clk     (clk),
    .sys_rst (sys_rst),
    .bit_en  (bit_en)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bit_cnt_r   <= 3'h0;
      chan_r      <= `BCR_LAST_CHANNEL;
      frame_start <= 1'b0;
    end else begin
      frame_start <= chan_edge & (chan_r == `BCR_LAST_CHANNEL);
      if (bit_en) begin
        bit_cnt_r <= bit_cnt_r + 3'h1;
      end
      if (chan_edge) begin
        chan_r <= chan_r + 9'h001;
      end
    end
  end

  // Fetch pipeline for the next channel, one stream per clock
  logic                fetch_busy_r;
  logic [3:0]          fetch_idx_r;
  logic [8:0]          fetch_chan_r;
  logic                p1_v_r;
  logic [3:0]          p1_idx_r;
  bcr_pkg::bcr_entry_t p1_ent_r;
  logic                p2_v_r;
  logic [3:0]          p2_idx_r;
  bcr_pkg::bcr_entry_t p2_ent_r;
  logic                p3_v_r;
  logic [3:0]          p3_idx_r;
  bcr_pkg::bcr_entry_t p3_ent_r;
  logic [7:0]          stage_byte_r [16];
  logic [15:0]         stage_act_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetch_busy_r <= 1'b0;
      fetch_idx_r  <= 4'h0;
      fetch_chan_r <= 9'h000;
    end else if (chan_edge) begin
      fetch_busy_r <= 1'b1;
      fetch_idx_r  <= 4'h0;
      fetch_chan_r <= chan_r + 9'h002;
    end else if (fetch_busy_r) begin
      fetch_idx_r  <= fetch_idx_r + 4'h1;
      fetch_busy_r <= (fetch_idx_r != `BCR_LAST_STREAM);
    end
  end

  always_ff @(posedge clk) begin
    p1_ent_r <= bcm_mem[{fetch_idx_r, fetch_chan_r}];
    p1_idx_r <= fetch_idx_r;
    p2_ent_r <= p1_ent_r;
    p2_idx_r <= p1_idx_r;
    p3_ent_r <= p2_ent_r;
    p3_idx_r <= p2_idx_r;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p1_v_r   <= 1'b0;
      p2_v_r   <= 1'b0;
      p3_v_r   <= 1'b0;
      dm_rd_en <= 1'b0;
      dm_req   <= '0;
    end else begin
      p1_v_r   <= fetch_busy_r & ~chan_edge;
      p2_v_r   <= p1_v_r;
      p3_v_r   <= p2_v_r;
      dm_rd_en <= p1_v_r & ~p1_ent_r.backplane_message_mode & ~init_busy_r;
      dm_req   <= '{backplane_source_select: p1_ent_r.backplane_source_select,
                    stream:  p1_ent_r.source_stream_number,
                    channel: p1_ent_r.source_channel_or_message};
    end
  end

  // Message mode takes the entry's low byte; source fields are not looked at
  wire [7:0] fetched_byte = p3_ent_r.backplane_message_mode ?
                            p3_ent_r.source_channel_or_message[7:0] : dm_rdata;

  for (genvar s = 0; s < `BCR_NUM_STREAMS; s++) begin : g_stream
    always_ff @(posedge clk) begin
      if (sys_rst) begin
        stage_byte_r[s] <= 8'hff;
        stage_act_r[s]  <= 1'b0;
      end else if (p3_v_r & (p3_idx_r == 4'(s))) begin
        stage_byte_r[s] <= fetched_byte;
        stage_act_r[s]  <= p3_ent_r.backplane_channel_enable & ~init_busy_r;
      end
    end

    bcr_shift_out u_shift (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .bit_en    (bit_en),
      .load      (chan_edge),
      .load_byte (stage_byte_r[s]),
      .load_act  (stage_act_r[s]),
      .drive_sel (drive_sel_s2_r),
      .sdo       (backplane_serial_outputs[s]),
      .sdo_oe    (backplane_serial_oe[s]),
      .act       (backplane_channel_active[s])
    );
  end

endmodule

// File: core/bcr_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the backplane connection block
// Assumes: Register offsets are host word addresses on the 14 low address bits
// Notes:   Included by bare name; definitions only
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

`define BCR_OFS_MAIN_CONTROL   14'h0000
`define BCR_OFS_BLOCK_PROG     14'h0001
`define BCR_OFS_LOCAL_IN_DLY   14'h0023
`define BCR_OFS_BP_IN_DLY      14'h0063
`define BCR_OFS_LOCAL_OUT_ADV  14'h0083
`define BCR_OFS_BP_OUT_ADV     14'h00a3
`define BCR_OFS_SELF_TEST      14'h014d
`define BCR_OFS_DEVICE_ID      14'h3fff
`define BCR_GRP_SPAN           14'h0010

`define BCR_CTRL_DISC_MODE_HI  15
`define BCR_CTRL_DISC_MODE_LO  13
`define BCR_CTRL_SAMPLE_MODE   12
`define BCR_CTRL_DISC_EN       10
`define BCR_CTRL_BLOCK_ARM     4
`define BCR_CTRL_RESET         16'h0000
`define BCR_REG_RESET          16'h0000

`define BCR_PT_3Q              2'h0
`define BCR_NUM_STREAMS        16
`define BCR_NUM_CHANNELS       512
`define BCR_MEM_DEPTH          8192
`define BCR_LAST_CHANNEL       9'h1ff
`define BCR_LAST_BIT           3'h7
`define BCR_LAST_STREAM        4'hf
`define BCR_LAST_ENTRY         13'h1fff
`define BCR_BIT_DIV            4

`endif

// File: core/bcr_pkg.sv
// Purpose: Types shared by the backplane connection block
// Assumes: Nothing beyond the constants header
// Notes:   Entry layout mirrors the 16-bit connection word
package bcr_pkg;

  typedef struct packed {
    logic       backplane_source_select;
    logic       backplane_message_mode;
    logic       backplane_channel_enable;
    logic [3:0] source_stream_number;
    logic [8:0] source_channel_or_message;
  } bcr_entry_t;

  typedef struct packed {
    logic       backplane_source_select;
    logic [3:0] stream;
    logic [8:0] channel;
  } bcr_dm_req_t;

  typedef struct packed {
    logic [1:0] point;
    logic [4:0] quarter_delay;
  } bcr_sample_t;

endpackage

// File: core/bcr_bit_div.sv
// Purpose: Bit-rate enable pulse from the system clock
// Assumes: DIV of at least 3 so a full stream fetch fits in a channel
// Notes:   One-cycle pulse every DIV clocks
`include "bcr_defs.svh"
module bcr_bit_div #(
  parameter int DIV = `BCR_BIT_DIV
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      bit_en
);

  logic [7:0] cnt_r;
  wire        last = (cnt_r == 8'(DIV - 1));

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r  <= 8'h00;
      bit_en <= 1'b0;
    end else begin
      cnt_r  <= last ? 8'h00 : cnt_r + 8'h01;
      bit_en <= last;
    end
  end

endmodule

// File: core/bcr_shift_out.sv
// Purpose: One backplane output stream serializer
// Assumes: load arrives together with bit_en at a channel boundary
// Notes:   Idle or inactive channels drive high or release the pin
module bcr_shift_out (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       bit_en,
  input  wire logic       load,
  input  wire logic [7:0] load_byte,
  input  wire logic       load_act,
  input  wire logic       drive_sel,
  output logic            sdo,
  output logic            sdo_oe,
  output logic            act
);

  logic [7:0] shift_r;
  wire  [7:0] shift_nxt = load ? load_byte : {shift_r[6:0], 1'b1};
  wire        act_nxt   = load ? load_act : act;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_r <= 8'hff;
      act     <= 1'b0;
      sdo     <= 1'b1;
      sdo_oe  <= 1'b0;
    end else if (bit_en) begin
      shift_r <= shift_nxt;
      act     <= act_nxt;
      sdo     <= act_nxt ? shift_nxt[7] : 1'b1;
      sdo_oe  <= act_nxt | drive_sel;
    end
  end

endmodule

// File: core/bcr_placeholder_none.sv
// Purpose: Intentionally empty compilation unit
// Assumes: Nothing
// Notes:   Holds no logic

// File: test/bcr_conn_mem_sva.sv
// Purpose: Port-level checks for the backplane connection block
// Assumes: Bench runs the block with BIT_DIV of 4
// Notes:   Bound to every instance of the top module
module bcr_conn_mem_sva #(
  parameter int BIT_DIV = 4
) (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        host_cs_n,
  input wire logic        host_rw,
  input wire logic        host_data_oe,
  input wire logic        host_ack,
  input wire logic        dm_rd_en,
  input wire logic [15:0] backplane_serial_outputs,
  input wire logic [15:0] backplane_serial_oe,
  input wire logic [15:0] backplane_channel_active,
  input wire logic        frame_start,
  input wire logic        discriminator_enable,
  input wire logic [2:0]  discriminator_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int FRAME = 512 * 8 * BIT_DIV;
  int   frame_cnt_r;
  logic seen_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Frame too long for a repetition, so count it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      frame_cnt_r <= 0;
      seen_r      <= 1'b0;
    end else if (frame_start) begin
      frame_cnt_r <= 1;
      seen_r      <= 1'b1;
    end else begin
      frame_cnt_r <= frame_cnt_r + 1;
    end
  end
  a_ack_latency: assert property ($fell(host_cs_n) |-> !host_ack [*3] ##[1:3] host_ack)
    else $error("host ack outside its latency window");
  a_ack_holds: assert property (host_ack && !host_cs_n |=> host_ack)
    else $error("host ack dropped while select still low");
  a_ack_release: assert property ($rose(host_cs_n) |-> ##[1:5] !host_ack)
    else $error("host ack not released after select rose");
  a_oe_on_read: assert property ($rose(host_data_oe) |-> host_ack && host_rw)
    else $error("data bus driven outside a read answer");
  a_mode_gated: assert property (!discriminator_enable |-> discriminator_mode == 3'h0)
    else $error("discriminator mode visible while disabled");
  a_frame_period: assert property (frame_start && seen_r |-> frame_cnt_r == FRAME)
    else $error("frame length differs from 512 channels");
  a_bit_hold: assert property ($changed(backplane_serial_outputs) |=> $stable(backplane_serial_outputs) [*3])
    else $error("serial bit shorter than one bit period");
  a_idle_high: assert property ((~backplane_channel_active & ~backplane_serial_outputs) == 16'h0000)
    else $error("inactive stream not held high");
  a_oe_active: assert property ((backplane_channel_active & ~backplane_serial_oe) == 16'h0000)
    else $error("active stream not driven");
  c_read: cover property (host_data_oe);
  c_fetch: cover property (dm_rd_en);
  c_frame: cover property (frame_start && seen_r);
endmodule

bind bcr_backplane_conn_mem bcr_conn_mem_sva #(.BIT_DIV(BIT_DIV)) u_sva (
  .clk(clk), .sys_rst(sys_rst), .host_cs_n(host_cs_n), .host_rw(host_rw), .host_data_oe(host_data_oe),
  .host_ack(host_ack), .dm_rd_en(dm_rd_en), .backplane_serial_outputs(backplane_serial_outputs),
  .backplane_serial_oe(backplane_serial_oe), .backplane_channel_active(backplane_channel_active),
  .frame_start(frame_start), .discriminator_enable(discriminator_enable),
  .discriminator_mode(discriminator_mode));

// File: test/bcr_dm_model.sv
// Purpose: Receive data memories seen from the backplane connection block
// Assumes: Answer is due the cycle after a read request
// Notes:   Byte is a fixed mix of the request so a wrong address shows
module bcr_dm_model (
  input  wire logic                 clk,
  input  wire logic                 rd_en,
  input  wire bcr_pkg::bcr_dm_req_t req,
  output logic      [7:0]           rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] rdata_r = 8'h00;
  wire  [7:0] mix     = req.channel[7:0] ^ {req.stream, 4'h0} ^ {req.backplane_source_select, 6'h00, req.channel[8]};
  assign rdata = rdata_r;
  // Outside a read the byte toggles, so a late sample cannot pass
  always @(posedge clk) begin
    if (rd_en)
      rdata_r <= mix;
    else
      rdata_r <= ~rdata_r;
  end
endmodule

// File: test/test_backplane_conn_mem_and_regs.sv
// Purpose: Register map, control fields and serial output checks
// Assumes: BIT_DIV of 4; connection memory usable after its sweep
// Notes:   Serial bits are sampled mid-bit from the channel's activation
module test_backplane_conn_mem_and_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          BIT_DIV = 4;
  localparam logic [15:0] ID_VAL  = 16'h3c96;  // Arbitrary value
  logic                 clk          = 1'b0;
  logic                 sys_rst      = 1'b1;
  logic                 host_cs_n    = 1'b1;
  logic                 host_rw      = 1'b1;
  logic [14:0]          host_addr    = 15'h0000;
  logic [15:0]          host_data_in = 16'h0000;
  logic                 drive_sel    = 1'b0;
  logic [15:0]          host_data_out, ser_out, ser_oe, ser_act, bprog;
  logic                 host_data_oe, host_ack, dm_rd_en, frame_start, disc_en, smode, arm;
  logic [2:0]           disc_mode;
  logic [7:0]           dm_rdata;
  bcr_pkg::bcr_dm_req_t dm_req;
  bcr_pkg::bcr_sample_t lcfg [16];
  bcr_pkg::bcr_sample_t bcfg [16];
  int                   error_cnt = 0;
  int                   checks    = 0;
  logic [13:0] regs [10] = '{14'h0001, 14'h0023, 14'h0032, 14'h0063, 14'h0072, 14'h0083, 14'h0092, 14'h00a3,
                             14'h00b2, 14'h014d};
  logic [13:0] holes [4] = '{14'h0002, 14'h0033, 14'h00b3, 14'h3ffe};
  logic [15:0] ctl [3]   = '{16'hf010, 16'hf410, 16'h1400};
  logic [5:0]  ctl_x [3] = '{6'h05, 6'h3f, 6'h06};
  logic [14:0] mem_a [4] = '{15'h4205, 15'h4406, 15'h4607, 15'h4808};
  logic [15:0] mem_d [4] = '{16'hfff5, 16'ha7f0, 16'h320c, 16'h40a5};

  always #4 clk = ~clk;

  bcr_backplane_conn_mem #(.BIT_DIV(BIT_DIV), .DEVICE_ID(ID_VAL)) DUT (
    .clk(clk), .sys_rst(sys_rst), .host_cs_n(host_cs_n), .host_rw(host_rw), .host_addr(host_addr),
    .host_data_in(host_data_in), .host_data_out(host_data_out), .host_data_oe(host_data_oe),
    .host_ack(host_ack), .backplane_output_drive_select(drive_sel), .dm_rd_en(dm_rd_en), .dm_req(dm_req),
    .dm_rdata(dm_rdata), .backplane_serial_outputs(ser_out), .backplane_serial_oe(ser_oe),
    .backplane_channel_active(ser_act), .frame_start(frame_start), .discriminator_enable(disc_en),
    .discriminator_mode(disc_mode), .sample_point_mode(smode), .block_program_arm(arm),
    .block_programming(bprog), .local_sample_cfg(lcfg), .backplane_sample_cfg(bcfg));

  bcr_dm_model u_dm (.clk(clk), .rd_en(dm_rd_en), .req(dm_req), .rdata(dm_rdata));

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic fail(input string nm);
    error_cnt++;
    $display("[ERR] %s expected done seen timeout", nm);
    summarize();
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Request held from select low until ack is sampled high
  task automatic host_xfer(input logic rd, input logic [14:0] a, input logic [15:0] wd, output logic [15:0] rv);
    int i;
    @(posedge clk);
    host_cs_n    <= 1'b0;
    host_rw      <= rd;
    host_addr    <= a;
    host_data_in <= wd;
    for (i = 0; i < 40 && host_ack !== 1'b1; i++) @(posedge clk);
    if (host_ack !== 1'b1) fail("host_ack");
    rv = host_data_out;
    host_cs_n <= 1'b1;
    for (i = 0; i < 40 && host_ack !== 1'b0; i++) @(posedge clk);
    if (host_ack !== 1'b0) fail("host_ack_release");
    repeat (3) @(posedge clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [15:0] d);
    logic [15:0] v;
    host_xfer(1'b0, a, d, v);
  endtask

  task automatic rd_chk(input string nm, input logic [14:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host_xfer(1'b1, a, 16'h0000, v);
    chk(nm, exp, v);
  endtask

  task automatic grab(input int s, input logic [7:0] exp);
    logic [7:0] got;
    int         i;
    for (i = 0; i < 20000 && ser_act[s] !== 1'b1; i++) @(posedge clk);
    if (ser_act[s] !== 1'b1) fail("serial_wait");
    @(posedge clk);
    chk("stream_oe", 16'h0001, {15'h0, ser_oe[s]});
    for (i = 7; i >= 0; i--) begin
      got[i] = ser_out[s];
      repeat (BIT_DIV) @(posedge clk);
    end
    chk("serial_byte", {8'h00, exp}, {8'h00, got});
  endtask

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd_chk("main_control", 15'h0000, 16'h0000);
    foreach (regs[i]) begin
      rd_chk("reg_reset", {1'b0, regs[i]}, 16'h0000);
      wr({1'b0, regs[i]}, {2'h0, regs[i]} ^ 16'ha5c3);
      rd_chk("reg_rw", {1'b0, regs[i]}, {2'h0, regs[i]} ^ 16'ha5c3);
    end
    chk("block_programming", 16'ha5c2, bprog);
    foreach (holes[i]) begin
      wr({1'b0, holes[i]}, 16'hffff);
      rd_chk("unmapped", {1'b0, holes[i]}, 16'h0000);
    end
    wr(15'h3fff, 16'h0000);
    rd_chk("device_id", 15'h3fff, ID_VAL);
    foreach (ctl[i]) begin
      wr(15'h0000, ctl[i]);
      rd_chk("main_control", 15'h0000, ctl[i]);
      chk("control_fields", {10'h0, ctl_x[i]}, {10'h0, disc_mode, smode, disc_en, arm});
    end
    // Sample mode high: every sample point code with whole-bit delays 4 to 7
    for (int p = 0; p < 4; p++) begin
      wr(15'h0063 + 15'(p), {11'h0, 3'(p + 4), 2'(p)});
      chk("bp_sample_cfg", {9'h0, 2'(p), 5'((p + 4) * 4)}, {9'h0, bcfg[p]});
    end
    wr(15'h0000, 16'h0000);
    wr(15'h0023, 16'h001f);
    chk("local_sample_cfg", 16'h001f, {9'h0, lcfg[0]});
    // Memory writes are dropped until the 8192-cycle sweep ends
    repeat (8300) @(posedge clk);
    foreach (mem_a[i]) wr(mem_a[i], mem_d[i]);
    rd_chk("conn_entry", 15'h4406, 16'ha7f0);
    rd_chk("mem_hole", 15'h6000, 16'h0000);
    fork
      grab(1, 8'hf5);
      grab(2, 8'h41);
      grab(3, 8'h9c);
    join
    drive_sel <= 1'b1;
    repeat (16) @(posedge clk);
    chk("oe_driven_high", 16'hffff, ser_oe);
    chk("idle_level", 16'hffff, ser_out);
    drive_sel <= 1'b0;
    repeat (16) @(posedge clk);
    chk("oe_released", 16'h0000, ser_oe);
    summarize();
  end
endmodule
